// ### hw/pidc_pkg.sv
// Constants for the page interleaved DRAM controller.
// Assumes a single clock domain driven by the doubled processor clock.
package pidc_pkg;
  // ==========================================================
  // Configuration port addresses and register indexes
  localparam logic [7:0] IDX_PORT = 8'h22;
  localparam logic [7:0] DATA_PORT = 8'h23;
  localparam logic [7:0] MEM_LAYOUT_IDX = 8'h00;
  localparam logic [7:0] BANK_TIMING_IDX = 8'h01;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] TIMING_WR_MASK = 8'h0F;
  // ==========================================================
  // Field positions in memory_layout_config
  localparam int LAY_INTERLEAVE = 0;
  localparam int LAY_BASE640 = 1;
  localparam int LAY_MAP_EN = 2;
  localparam int LAY_REGION_RO = 3;
  localparam int LAY_REGION_LOW = 4;
  localparam int LAY_HI_BANKS = 5;
  localparam int LAY_TMO_DIS = 6;
  localparam int LAY_TYPE_1M = 7;
  // Field positions in bank_timing_config
  localparam int TIM_ZWS_LO = 0;
  localparam int TIM_PRE4_LO = 1;
  localparam int TIM_ZWS_HI = 2;
  localparam int TIM_PRE4_HI = 3;
  // ==========================================================
  // Timing counts in doubled-clock periods
  localparam logic [3:0] PRE_LONG = 4'h6;
  localparam logic [3:0] PRE_SHORT = 4'h4;
  localparam logic [3:0] RAS_CYC = 4'h2;
  localparam logic [3:0] CAS_CYC = 4'h2;
  localparam logic [3:0] REF_STAGGER = 4'h1;
  localparam real RAS_TMO_US = 10.0;
  localparam real CLK_NS = 40.0;
  localparam int RAS_TMO_CYC = int'(RAS_TMO_US * 1000.0 / CLK_NS) - 1;
  // Region bases (address bits 23:17)
  localparam logic [6:0] REGION_HI = 7'h7F;
  localparam logic [6:0] REGION_LO = 7'h07;
  localparam logic [23:0] TOP_16M = 24'hFFFFFF;
endpackage

// ### hw/pidc_addr_map.sv
// Row/column address generation and bank selection.
// Assumes address bits are stable for the whole access.
`timescale 1ns/10ps
module pidc_addr_map (
  input wire logic [23:2] addr,
  input wire logic type_1m,
  input wire logic interleave,
  input wire logic hi_banks,
  output logic [1:0] bank,
  output logic [9:0] row,
  output logic [9:0] col
);
  // ==========================================================
  // Bank choice and address fields
  always_comb begin
    bank = 2'h0;
    row = 10'h000;
    col = 10'h000;
    if (!interleave) begin
      if (type_1m) begin
        row = addr[21:12];
        col = addr[11:2];
      end else begin
        row = {2'h0, addr[18:11]};
        col = {1'h0, addr[10:2]};
      end
    end else begin
      bank[0] = addr[11];
      if (hi_banks) begin
        bank[1] = type_1m ? addr[23] : addr[21];
      end
      if (type_1m) begin
        row = addr[21:12];
        col = {addr[22], addr[10:2]};
      end else begin
        row = {1'h0, addr[20:12]};
        col = {1'h0, addr[10:2]};
      end
    end
  end
endmodule

// ### hw/pidc_ctrl.sv
// Page interleaved DRAM controller top: configuration port, sequencers, strobes.
// Assumes all inputs synchronous to clk (doubled processor clock).
//
// Summary of operation
// - Two interleaved banks: even pages to bank 0, odd pages to bank 1.
// - Four banks: upper pair holds even pages in bank 2, odd in 3.
// - Separate processor, DMA, refresh sequencers chosen by refresh and hold acknowledge.
// - One processor sequencer serves both modes; strobes follow configuration registers.
// - DMA sequencer drives strobes during DMA transfers.
// - Refresh row strobes are staggered across banks.
// - Layout bit 6 set disables the row-open timeout; default enabled.
// - Layout bit 5 enables banks 2 and 3; default off.
// - Bit 4 moves 128K region low; bit 3 makes it read-only.
// - Timing bit 3: banks 2/3 precharge four instead of six clocks.
// - Timing bit 1: banks 0/1 precharge four instead of six clocks.
// - Timing bit 2: banks 2/3 reads need no wait state.
// - Timing bit 0: banks 0/1 reads need no wait state.
// - Decoder serves one, two or four banks of either DRAM type.
// - Layout bit 7 selects DRAM type; address fields follow type.
// - Mux lines carry addresses, and register data during configuration access.
// - Buffer enable asserted during configuration I/O cycles.
// - Row, column strobes and write enable driven for every bank.
// - Index written at port 22H, data accessed at port 23H.
// - Mode pin low gives direct access; high gives page operation.
// - Base 512K or 640K; remainder remapped just below 16MB.
`timescale 1ns/10ps
module pidc_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic [23:2] addr,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic mode_page,
  input wire logic refresh_req,
  input wire logic hold_acknowledge_in,
  input wire logic dma_ras_req,
  input wire logic dma_cas_req,
  input wire logic dma_mux,
  input wire logic io_sel,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic port_a0,
  input wire logic [1:0] ref_addr_hi,
  input wire logic [7:0] mux_addr_data_lines_in,
  output logic [7:0] mux_addr_data_lines_out,
  output logic mux_addr_data_lines_oe,
  output logic dram_addr_bit8,
  output logic dram_addr_bit9,
  output logic [3:0] ras_n,
  output logic [3:0] cas_n,
  output logic we_n,
  output logic mem_ready,
  output logic region_hit,
  output logic region_write_blocked,
  output logic config_buffer_enable
);
  typedef enum {SQ_IDLE, SQ_ROW, SQ_COL, SQ_OPEN, SQ_PRE, SQ_DMA, SQ_REF} pidc_seq_t;
  typedef struct packed {
    logic [7:0] layout;
    logic [7:0] timing;
    logic [7:0] index;
    pidc_seq_t seq;
    logic [3:0] cnt;
    logic [8:0] tmo;
    logic [1:0] bank;
    logic [9:0] open_row;
    logic [3:0] ras;
    logic [3:0] cas;
    logic we;
    logic rdy;
    logic [9:0] ma;
    logic [7:0] rdata;
  } pidc_state_t;
  pidc_state_t cur_ff;
  pidc_state_t nxt_cur;
  logic [1:0] map_bank;
  logic [9:0] map_row;
  logic [9:0] map_col;
  logic hi_pair;
  logic [3:0] pre_cnt;
  logic zero_ws;
  logic page_hit;
  logic cfg_cycle;
  logic [6:0] reg_base;
  logic [23:2] phys_addr;
  // Elaboration check on timeout count width
  if (pidc_pkg::RAS_TMO_CYC > 511) begin : g_chk
    $error("timeout count does not fit counter");
  end
  // ==========================================================
  // Address decoder
  // Remap window below 16MB folds back onto the area between base and 1MB
  assign phys_addr = (cur_ff.layout[pidc_pkg::LAY_MAP_EN] && addr[23:20] == 4'hF
                      && addr[19:17] >= (cur_ff.layout[pidc_pkg::LAY_BASE640] ? 3'h5 : 3'h4))
                     ? {4'h0, addr[19:2]} : addr;
  pidc_addr_map u_map (
    .addr(phys_addr),
    .type_1m(cur_ff.layout[pidc_pkg::LAY_TYPE_1M]),
    .interleave(cur_ff.layout[pidc_pkg::LAY_INTERLEAVE] & mode_page),
    .hi_banks(cur_ff.layout[pidc_pkg::LAY_HI_BANKS]),
    .bank(map_bank),
    .row(map_row),
    .col(map_col)
  );
  // Region decode and read-only write blocking
  assign reg_base = cur_ff.layout[pidc_pkg::LAY_REGION_LOW] ? pidc_pkg::REGION_LO
                                                             : pidc_pkg::REGION_HI;
  assign region_hit = (addr[23:17] == reg_base);
  assign region_write_blocked = region_hit & mem_write
                                & cur_ff.layout[pidc_pkg::LAY_REGION_RO];
  // Per-pair timing selection
  assign hi_pair = cur_ff.bank[1];
  assign pre_cnt = (hi_pair ? cur_ff.timing[pidc_pkg::TIM_PRE4_HI]
                            : cur_ff.timing[pidc_pkg::TIM_PRE4_LO])
                   ? pidc_pkg::PRE_SHORT : pidc_pkg::PRE_LONG;
  assign zero_ws = map_bank[1] ? cur_ff.timing[pidc_pkg::TIM_ZWS_HI]
                               : cur_ff.timing[pidc_pkg::TIM_ZWS_LO];
  assign page_hit = mode_page && (map_bank == cur_ff.bank) && (map_row == cur_ff.open_row);
  assign cfg_cycle = io_sel & (io_rd | io_wr);
  // ==========================================================
  // Next state
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.rdy = 1'b0;
    // Configuration port access
    if (io_sel && io_wr) begin
      if (!port_a0) begin
        nxt_cur.index = mux_addr_data_lines_in;
      end else if (cur_ff.index == pidc_pkg::MEM_LAYOUT_IDX) begin
        nxt_cur.layout = mux_addr_data_lines_in;
      end else if (cur_ff.index == pidc_pkg::BANK_TIMING_IDX) begin
        nxt_cur.timing = mux_addr_data_lines_in & pidc_pkg::TIMING_WR_MASK;
      end
    end
    unique case (cur_ff.index)
      pidc_pkg::MEM_LAYOUT_IDX: nxt_cur.rdata = cur_ff.layout;
      pidc_pkg::BANK_TIMING_IDX: nxt_cur.rdata = cur_ff.timing;
      default: nxt_cur.rdata = 8'h00;
    endcase
    if (cur_ff.seq == SQ_OPEN && cur_ff.tmo != 9'h000) begin
      nxt_cur.tmo = cur_ff.tmo - 9'h001;
    end
    if (cur_ff.cnt != 4'h0) begin
      nxt_cur.cnt = cur_ff.cnt - 4'h1;
    end
    unique case (cur_ff.seq)
      SQ_IDLE, SQ_OPEN: begin
        // Selector: refresh first, then DMA, then processor
        if (refresh_req) begin
          nxt_cur.seq = SQ_REF;
          nxt_cur.ras = 4'hF;
          nxt_cur.cas = 4'hF;
          nxt_cur.cnt = pidc_pkg::REF_STAGGER;
          nxt_cur.ma = {ref_addr_hi, 8'h00};
        end else if (hold_acknowledge_in) begin
          nxt_cur.seq = SQ_DMA;
          nxt_cur.ras = 4'hF;
          nxt_cur.cas = 4'hF;
        end else if (cur_ff.seq == SQ_OPEN && mode_page && !cur_ff.layout[pidc_pkg::LAY_TMO_DIS]
                     && cur_ff.tmo == 9'h000) begin
          nxt_cur.seq = SQ_PRE;
          nxt_cur.ras = 4'hF;
          nxt_cur.cnt = pre_cnt;
        end else if (mem_req && !region_write_blocked) begin
          nxt_cur.we = mem_write;
          if (cur_ff.seq == SQ_OPEN && page_hit) begin
            nxt_cur.ma = map_col;
            nxt_cur.cas[cur_ff.bank] = 1'b0;
            nxt_cur.seq = SQ_COL;
            nxt_cur.cnt = (zero_ws || mem_write) ? 4'h0 : 4'h1;
          end else if (cur_ff.seq == SQ_OPEN) begin
            nxt_cur.ras = 4'hF;
            nxt_cur.seq = SQ_PRE;
            nxt_cur.cnt = pre_cnt;
          end else begin
            nxt_cur.bank = map_bank;
            nxt_cur.open_row = map_row;
            nxt_cur.ma = map_row;
            nxt_cur.ras[map_bank] = 1'b0;
            nxt_cur.seq = SQ_ROW;
            nxt_cur.cnt = pidc_pkg::RAS_CYC - 4'h1;
            nxt_cur.tmo = 9'(pidc_pkg::RAS_TMO_CYC);
          end
        end
      end
      SQ_ROW: begin
        if (cur_ff.cnt == 4'h0) begin
          nxt_cur.ma = map_col;
          nxt_cur.cas[cur_ff.bank] = 1'b0;
          nxt_cur.seq = SQ_COL;
          nxt_cur.cnt = (zero_ws || cur_ff.we) ? 4'h0 : 4'h1;
        end
      end
      SQ_COL: begin
        if (cur_ff.cnt == 4'h0) begin
          nxt_cur.rdy = 1'b1;
          nxt_cur.cas = 4'hF;
          nxt_cur.we = 1'b0;
          // Direct mode closes the row after every access
          if (mode_page) begin
            nxt_cur.seq = SQ_OPEN;
          end else begin
            nxt_cur.ras = 4'hF;
            nxt_cur.seq = SQ_PRE;
            nxt_cur.cnt = pre_cnt;
          end
        end
      end
      SQ_PRE: begin
        if (cur_ff.cnt == 4'h0) begin
          nxt_cur.seq = SQ_IDLE;
        end
      end
      SQ_DMA: begin
        // DMA strobes follow the DMA timing inputs
        nxt_cur.ras = {4{~dma_ras_req}};
        nxt_cur.cas = {4{~dma_cas_req}};
        nxt_cur.ma = dma_mux ? {addr[21], addr[10:2]} : {addr[20:11]};
        if (!hold_acknowledge_in) begin
          nxt_cur.seq = SQ_PRE;
          nxt_cur.ras = 4'hF;
          nxt_cur.cas = 4'hF;
          nxt_cur.cnt = pidc_pkg::PRE_LONG;
        end
      end
      SQ_REF: begin
        // One more bank's row strobe drops each stagger step
        if (cur_ff.cnt == 4'h0 && cur_ff.ras != 4'h0) begin
          nxt_cur.ras = {cur_ff.ras[2:0], 1'b0};
          nxt_cur.cnt = pidc_pkg::REF_STAGGER;
        end
        if (!refresh_req) begin
          nxt_cur.ras = 4'hF;
          nxt_cur.seq = SQ_PRE;
          nxt_cur.cnt = pidc_pkg::PRE_LONG;
        end
      end
    endcase
  end
  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      cur_ff <= '{layout: pidc_pkg::CFG_RESET, timing: pidc_pkg::CFG_RESET,
                  index: 8'h00, seq: SQ_IDLE, cnt: 4'h0, tmo: 9'h000, bank: 2'h0,
                  open_row: 10'h000, ras: 4'hF, cas: 4'hF, we: 1'b0, rdy: 1'b0,
                  ma: 10'h000, rdata: 8'h00};
    end else begin
      cur_ff <= nxt_cur;
    end
  end
  // ==========================================================
  // Outputs
  // Lines turn to input for port writes and for index port reads
  assign mux_addr_data_lines_oe = ~(io_sel & (io_wr | (io_rd & ~port_a0)));
  assign mux_addr_data_lines_out = (io_sel & io_rd) ? cur_ff.rdata : cur_ff.ma[7:0];
  assign dram_addr_bit8 = cur_ff.ma[8];
  assign dram_addr_bit9 = cur_ff.ma[9];
  assign ras_n = cur_ff.ras;
  assign cas_n = cur_ff.cas;
  assign we_n = ~cur_ff.we;
  assign mem_ready = cur_ff.rdy;
  assign config_buffer_enable = cfg_cycle;
  // ==========================================================
  // Checks
  reset_clear_a: assert property (@(posedge clk) reset |=> cur_ff.layout == 8'h00 && cur_ff.timing == 8'h00) else $error("config not cleared");
  reserved_zero_a: assert property (@(posedge clk) disable iff (reset) cur_ff.timing[7:4] == 4'h0) else $error("reserved timing bits set");
  buf_en_a: assert property (@(posedge clk) cfg_cycle |-> config_buffer_enable) else $error("buffer enable missing");
  dma_strobe_a: assert property (@(posedge clk) disable iff (reset) cur_ff.seq == SQ_DMA && hold_acknowledge_in && !refresh_req |=> cur_ff.ras == {4{~$past(dma_ras_req)}}) else $error("dma ras mismatch");
  ref_stagger_a: assert property (@(posedge clk) disable iff (reset) cur_ff.seq == SQ_REF && $past(cur_ff.seq) != SQ_REF |-> cur_ff.ras == 4'hF) else $error("refresh not staggered");
  sel_refresh_a: assert property (@(posedge clk) disable iff (reset) cur_ff.seq == SQ_IDLE && refresh_req |=> cur_ff.seq == SQ_REF) else $error("refresh not chosen");
  precharge_len_a: assert property (@(posedge clk) disable iff (reset) cur_ff.seq != SQ_PRE ##1 cur_ff.seq == SQ_PRE && cur_ff.cnt == 4'h4 |-> ##4 cur_ff.seq == SQ_PRE ##1 cur_ff.seq == SQ_IDLE) else $error("short precharge wrong");
  one_bank_a: assert property (@(posedge clk) disable iff (reset) cur_ff.seq == SQ_ROW |-> $countones(~cur_ff.ras) == 1) else $error("row strobe not one bank");
  hi_bank_off_a: assert property (@(posedge clk) disable iff (reset) !cur_ff.layout[5] && cur_ff.seq == SQ_ROW |-> cur_ff.ras[3:2] == 2'b11) else $error("upper banks used");
  ro_region_a: assert property (@(posedge clk) disable iff (reset) region_write_blocked && cur_ff.seq == SQ_IDLE |=> cur_ff.seq != SQ_ROW) else $error("write to read-only region");
endmodule

// ### dv/pidc_dram_model.sv
// DRAM bank model: notes which bank opened a row and the row address it took.
// Assumes strobes and address lines from the controller settle before the falling clock edge.
`timescale 1ns/10ps
module pidc_dram_model (
  input wire logic clk,
  input wire logic [3:0] ras_n,
  input wire logic [7:0] addr_lines,
  input wire logic addr_bit8,
  input wire logic addr_bit9,
  output logic [1:0] opened_bank,
  output logic [9:0] opened_row
);
  logic [3:0] prev_ras_n;
  // ==========================================================
  // Row latch
  initial begin
    prev_ras_n = 4'hF;
    opened_bank = 2'h0;
    opened_row = 10'h000;
  end
  // Take the row address as any bank's row strobe falls
  always @(negedge clk) begin
    for (int b = 3; b >= 0; b--) begin
      if (prev_ras_n[b] === 1'b1 && ras_n[b] === 1'b0) begin
        opened_bank = 2'(b);
        opened_row = {addr_bit9, addr_bit8, addr_lines};
      end
    end
    prev_ras_n = ras_n;
  end
endmodule

// ### dv/test_page_interleaved_dram_controller.sv
// Self-checking bench for the DRAM controller: registers, decode, timing, refresh, DMA.
// Assumes the controller and the DRAM model compile alongside; one 25 MHz clock.
`timescale 1ns/10ps
module test_page_interleaved_dram_controller;
  typedef struct {logic [1:0] bank; logic [9:0] row; logic [9:0] mask;} pidc_note_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [23:2] addr = '0;
  logic mem_req = 1'b0, mem_write = 1'b0, mode_page = 1'b0, refresh_req = 1'b0;
  logic hold_acknowledge_in = 1'b0, dma_ras_req = 1'b0, dma_cas_req = 1'b0, dma_mux = 1'b0;
  logic io_sel = 1'b0, io_rd = 1'b0, io_wr = 1'b0, port_a0 = 1'b0, bench_drv = 1'b0;
  logic [7:0] bench_data = 8'h00;
  logic [7:0] md_in, md_out;
  logic md_oe, ab8, ab9, we_n, mem_ready, region_hit, region_write_blocked, cbe;
  logic [3:0] ras_n, cas_n;
  logic [1:0] model_bank;
  logic [9:0] model_row;
  logic [15:0] seed = 16'h0062;
  int n_mismatch = 0;
  int samples_checked = 0;
  pidc_note_t notes[$];
  pidc_note_t note;
  // ==========================================================
  // Clock, pulled-up data lines, design and DRAM model
  always #20 clk = ~clk;
  assign md_in = md_oe ? md_out : (bench_drv ? bench_data : 8'hFF);
  pidc_ctrl i_dut (.clk(clk), .reset(reset), .addr(addr), .mem_req(mem_req),
    .mem_write(mem_write), .mode_page(mode_page), .refresh_req(refresh_req),
    .hold_acknowledge_in(hold_acknowledge_in), .dma_ras_req(dma_ras_req),
    .dma_cas_req(dma_cas_req), .dma_mux(dma_mux), .io_sel(io_sel), .io_rd(io_rd),
    .io_wr(io_wr), .port_a0(port_a0), .ref_addr_hi(2'h0), .mux_addr_data_lines_in(md_in),
    .mux_addr_data_lines_out(md_out), .mux_addr_data_lines_oe(md_oe),
    .dram_addr_bit8(ab8), .dram_addr_bit9(ab9), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .mem_ready(mem_ready), .region_hit(region_hit),
    .region_write_blocked(region_write_blocked), .config_buffer_enable(cbe));
  pidc_dram_model i_dram (.clk(clk), .ras_n(ras_n), .addr_lines(md_out), .addr_bit8(ab8),
    .addr_bit9(ab9), .opened_bank(model_bank), .opened_row(model_row));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    samples_checked++;
    if (act !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic do_reset;
    step(1);
    reset = 1'b1;
    step(2);
    reset = 1'b0;
  endtask
  task automatic io_wr_cyc(input logic a0, input logic [7:0] d);
    step(1);
    io_sel = 1'b1;
    io_wr = 1'b1;
    port_a0 = a0;
    bench_drv = 1'b1;
    bench_data = d;
    #1 chk({15'h0, cbe}, 16'h0001);
    step(1);
    io_sel = 1'b0;
    io_wr = 1'b0;
    bench_drv = 1'b0;
  endtask
  task automatic wcfg(input logic [7:0] idx, input logic [7:0] val);
    io_wr_cyc(1'b0, idx);
    io_wr_cyc(1'b1, val);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    io_wr_cyc(1'b0, idx);
    step(1);
    io_sel = 1'b1;
    io_rd = 1'b1;
    port_a0 = 1'b1;
    step(2);
    chk({6'h0, md_oe, cbe, md_out}, {8'h03, exp});
    io_sel = 1'b0;
    io_rd = 1'b0;
  endtask
  task automatic mem_acc(input logic [23:2] a, output int n);
    step(1);
    addr = a;
    mem_req = 1'b1;
    n = 0;
    do begin
      step(1);
      n++;
    end while (mem_ready !== 1'b1 && n < 40);
    mem_req = 1'b0;
    if (n >= 40) chk(16'(n), 16'h0000);
  endtask
  function automatic logic [23:2] rnd_addr();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return 22'({seed, seed[15:10]});
  endfunction
  // ==========================================================
  // Result watcher: each ready pulse settles the oldest note
  always @(negedge clk) begin
    if (mem_ready === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      chk({4'h0, model_bank, model_row & note.mask}, {4'h0, note.bank, note.row & note.mask});
    end
  end
  // Watchdog cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
  // ==========================================================
  // Main sequence
  initial begin
    int n, l1, l0, l6, l4, lh;
    logic [23:2] a;
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h01, 8'h00);
    wcfg(8'h01, 8'hFF);
    rd_chk(8'h01, 8'h0F);
    wcfg(8'h00, 8'h5A);
    rd_chk(8'h00, 8'h5A);
    rd_chk(8'h02, 8'h00);
    do_reset();
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h01, 8'h00);
    $display("test registers done");
    // Region decode at both bases, read-only write blocking
    mem_write = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wcfg(8'h00, k ? 8'h18 : 8'h00);
      addr = 22'(24'hFE0000 >> 2);
      #1 chk({14'h0, region_hit, region_write_blocked}, k ? 16'h0000 : 16'h0002);
      addr = 22'(24'h0E0000 >> 2);
      #1 chk({14'h0, region_hit, region_write_blocked}, k ? 16'h0003 : 16'h0000);
    end
    mem_write = 1'b0;
    $display("test region done");
    // Single bank row fields for both DRAM types
    for (int k = 0; k < 2; k++) begin
      do_reset();
      wcfg(8'h00, k ? 8'h80 : 8'h00);
      a = rnd_addr() & 22'h07FFFF;
      notes.push_back('{2'h0, k ? 10'(a[21:12]) : 10'(a[18:11]), k ? 10'h3FF : 10'h0FF});
      mem_acc(a, n);
    end
    // Remap window: F80800 lands at 080800, row field 01
    do_reset();
    wcfg(8'h00, 8'h04);
    notes.push_back('{2'h0, 10'h001, 10'h0FF});
    mem_acc(22'(24'hF80800 >> 2), n);
    // Interleaved pages across four banks, zero-wait reads programmed alongside
    wcfg(8'h00, 8'h21);
    wcfg(8'h01, 8'h05);
    mode_page = 1'b1;
    for (int i = 0; i < 4; i++) begin
      a = rnd_addr() & 22'h0FFFFF;
      a[11] = i[0];
      a[21] = i[1];
      notes.push_back('{2'(i), 10'(a[20:12]), 10'h1FF});
      mem_acc(a, n);
    end
    $display("test decode done");
    // Read wait states and precharge per bank pair
    for (int p = 0; p < 2; p++) begin
      // Upper pair is reached only through four-bank interleave in page mode
      mode_page = p[0];
      a = p ? 22'(24'h200000 >> 2) : 22'h0;
      for (int w = 0; w < 2; w++) begin
        do_reset();
        wcfg(8'h00, p ? 8'h21 : 8'h00);
        wcfg(8'h01, p ? (w ? 8'h05 : 8'h01) : (w ? 8'h01 : 8'h00));
        if (w) mem_acc(a, l0);
        else mem_acc(a, l1);
      end
      chk(16'(l1 - l0), 16'h0001);
      mode_page = 1'b1;
      mem_acc(a, n);
      mem_acc(a | 22'h000400, l6);
      wcfg(8'h01, p ? 8'h0F : 8'h03);
      mem_acc(a, l4);
      chk(16'(l6 - l4), 16'h0002);
      mem_acc(a, lh);
      chk({15'h0, lh < l4}, 16'h0001);
    end
    $display("test timing done");
    // Staggered refresh starts with bank 0 alone
    mode_page = 1'b0;
    do_reset();
    refresh_req = 1'b1;
    n = 0;
    while (ras_n === 4'hF && n < 20) begin
      step(1);
      n++;
    end
    chk({12'h0, ras_n}, 16'h000E);
    step(6);
    refresh_req = 1'b0;
    step(12);
    $display("test refresh done");
    // DMA strobes follow the DMA requests
    hold_acknowledge_in = 1'b1;
    dma_ras_req = 1'b1;
    step(3);
    chk({11'h0, ras_n !== 4'hF, cas_n}, 16'h001F);
    dma_mux = 1'b1;
    dma_cas_req = 1'b1;
    step(3);
    chk({15'h0, cas_n !== 4'hF}, 16'h0001);
    {hold_acknowledge_in, dma_ras_req, dma_cas_req, dma_mux} = 4'h0;
    step(8);
    $display("test dma done");
    tally_and_finish();
  end
endmodule
